// ==== rtl/nvrc_pkg.sv ====
// Package for the record-check and raw SPI command interpreter.
// Assumes one 10 MHz clock and a synchronous active-high reset.
`default_nettype none
package nvrc_pkg;
   localparam logic [15:0] CMD_RECORD_CHECK = 16'h850d;
   localparam logic [15:0] CMD_CHECK_STATUS = 16'h850e;
   localparam logic [15:0] CMD_RAW_ISSUE = 16'h850f;
   localparam logic [15:0] CMD_RAW_RESPONSE = 16'h8510;
   // Result codes; values are local choices
   localparam logic [7:0] RESULT_OK = 8'h00;
   localparam logic [7:0] RESULT_NO_DEVICE = 8'h01;
   localparam logic [7:0] RESULT_BAD_DESCRIPTOR = 8'h02;
   localparam logic [7:0] RESULT_OUT_OF_RANGE = 8'h03;
   localparam logic [7:0] RESULT_BUSY = 8'h04;
   localparam logic [7:0] RESULT_UNSUPPORTED = 8'h05;
   localparam logic [7:0] RESULT_ACCESS_DENIED = 8'h06;
   localparam logic [7:0] RESULT_OUT_OF_MEMORY = 8'h07;
   localparam logic [7:0] RESULT_ALREADY_RUNNING = 8'h08;
   localparam logic [7:0] RESULT_CHECKSUM = 8'h09;
   // Request and response byte offsets
   localparam int OFS_RAW_OPCODE = 0;
   localparam int OFS_RAW_TX_LEN = 1;
   localparam int OFS_RAW_RX_LEN = 2;
   localparam int OFS_RAW_TX_DATA = 3;
   localparam int OFS_CHK_ERROR = 0;
   localparam int OFS_CHK_TYPE = 1;
   localparam int OFS_CHK_LENGTH = 2;
   localparam int OFS_CHK_HDR_SUM = 4;
   localparam int OFS_CHK_CALC_SUM = 6;
   localparam int OFS_CHK_ADDR = 8;
   localparam int OFS_CHK_COUNT = 12;
   localparam logic [8:0] RAW_TX_MAX = 9'd253;
   localparam logic [8:0] RAW_RX_MAX = 9'd256;
   // Record type codes; arbitrary encodings
   localparam logic [7:0] REC_DIRECTORY = 8'h01;
   localparam logic [7:0] REC_STARTUP_TABLE = 8'h02;
   localparam logic [7:0] REC_PATCH_DIR = 8'h03;
   localparam logic [7:0] REC_OVERLAY_DIR_LO = 8'h04;
   localparam logic [7:0] REC_OVERLAY_DIR_HI = 8'h07;
   localparam logic [7:0] REC_CMD_SEQ_DIR = 8'h08;
   localparam logic [7:0] REC_CMD_SEQ = 8'h09;
   localparam logic [7:0] REC_XFORM_DIR = 8'h0a;
   localparam logic [7:0] REC_NULL = 8'h00;
   localparam logic [7:0] REC_NULL_EXT = 8'hff;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_CHECK = 3'b001, ST_RAW_CMD = 3'b010,
      ST_RAW_TX = 3'b011, ST_RAW_RX = 3'b100, ST_RAW_END = 3'b101
   } nvrc_state_type;

   // Host command channel
   typedef struct packed {
      logic valid;
      logic [15:0] code;
      logic meta_only;
      logic [7:0] opcode;
      logic [7:0] tx_len;
      logic [8:0] rx_len;
   } nvrc_cmd_type;

   // Record fetched by the record walker
   typedef struct packed {
      logic valid;
      logic last;
      logic [7:0] rtype;
      logic [15:0] length;
      logic [15:0] hdr_sum;
      logic [15:0] calc_sum;
      logic [31:0] addr;
   } nvrc_record_type;

   // Check-status report
   typedef struct packed {
      logic [7:0] error;
      logic [7:0] rtype;
      logic [15:0] length;
      logic [15:0] hdr_sum;
      logic [15:0] calc_sum;
      logic [31:0] addr;
      logic [15:0] count;
   } nvrc_report_type;

   // SPI byte engine request
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] data;
   } nvrc_spi_req_type;
endpackage
`default_nettype wire

// ==== rtl/nvrc_rx_mem.sv ====
// Receive buffer of 256 bytes for raw SPI reads.
// Assumes one clock; read data is registered.
`default_nettype none
module nvrc_rx_mem
   import nvrc_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Write port
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   // Read port
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] mem [0:255];

   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule
`default_nettype wire

// ==== rtl/nvrc_top.sv ====
// Command interpreter for record checking and raw SPI memory commands.
// Assumes a record walker delivers records and an SPI byte engine moves bytes.
// Overview of operation
// - Record check takes and frees lock itself
// - Lock unavailable gives access denied
// - No memory or directory gives no device
// - Borrow RAM, out of memory, release
// - Metadata flag restricts check to metadata records
// - Classify metadata and data record types
// - Filler records end the check
// - Stop at first checksum mismatch
// - One-time-program images are never checked
// - Status query: ok when done, busy otherwise
// - Report fields at fixed response offsets
// - Record count includes the failing record
// - Raw command sends opcode, then transmit bytes
// - Opcode at +0, transmit count at +1
// - Receive count at +2, read afterwards
// - Transmit data from +3, ignored if none
// - Non-SPI bad descriptor, missing no device
// - Counts out of range refused
// - Raw command needs host-held lock
// - Busy while running, else ok
// - Opcode forwarded without decoding
// - Record check compares stored to computed sums
// - Response query returns status and bytes
`default_nettype none
module nvrc_top
   import nvrc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Host command channel
   input wire nvrc_cmd_type cmd,
   output logic [7:0] cmd_result,
   output logic cmd_done,
   // Memory environment
   input wire logic mem_present,
   input wire logic mem_is_spi,
   input wire logic directory_valid,
   input wire logic image_is_otp,
   input wire logic host_holds_lock,
   input wire logic lock_free,
   output logic lock_take,
   output logic lock_release,
   input wire logic ram_free,
   output logic ram_borrow,
   output logic ram_return,
   // Record walker
   output logic rec_start,
   output logic rec_meta_only,
   output logic rec_next,
   input wire nvrc_record_type rec,
   // Check report
   output nvrc_report_type report,
   // Transmit payload source
   output logic [7:0] tx_index,
   input wire logic [7:0] tx_byte,
   // SPI byte engine
   output nvrc_spi_req_type spi_req,
   output logic spi_select,
   input wire logic spi_ack,
   input wire logic [7:0] spi_rx_byte,
   // Received data readback
   input wire logic [7:0] rx_rd_addr,
   output logic [7:0] rx_rd_data,
   output logic [8:0] rx_count
);
   typedef struct packed {
      nvrc_state_type st;
      logic [7:0] result;
      logic done;
      logic lock_take;
      logic lock_release;
      logic ram_borrow;
      logic ram_return;
      logic rec_start;
      logic meta_only;
      logic rec_next;
      nvrc_report_type rpt;
      logic [7:0] opcode;
      logic [7:0] tx_left;
      logic [8:0] rx_left;
      logic [7:0] tx_idx;
      logic [8:0] rx_cnt;
      logic [7:0] raw_status;
      nvrc_spi_req_type spi;
      logic sel;
      logic rx_we;
      logic [7:0] rx_data;
   } nvrc_regs_type;

   nvrc_regs_type r_q, r_d;

   function automatic logic is_metadata(input logic [7:0] t);
      return t == REC_DIRECTORY || t == REC_STARTUP_TABLE || t == REC_PATCH_DIR ||
         (t >= REC_OVERLAY_DIR_LO && t <= REC_OVERLAY_DIR_HI) ||
         t == REC_CMD_SEQ_DIR || t == REC_CMD_SEQ || t == REC_XFORM_DIR;
   endfunction

   // Filler records carry no usable checksum
   function automatic logic is_filler(input logic [7:0] t);
      return t == REC_NULL || t == REC_NULL_EXT;
   endfunction

   // Meta-only runs skip data records, so their sums never fail a check
   function automatic logic is_checked(input logic meta, input logic [7:0] t);
      return !meta || is_metadata(t);
   endfunction

   nvrc_rx_mem u_rx_mem (
      .core_clk(core_clk),
      .wr_en(r_q.rx_we),
      .wr_addr(r_q.rx_cnt[7:0]),
      .wr_data(r_q.rx_data),
      .rd_addr(rx_rd_addr),
      .rd_data(rx_rd_data)
   );

   always_comb begin
      r_d = r_q;
      r_d.done = 1'b0;
      r_d.lock_take = 1'b0;
      r_d.lock_release = 1'b0;
      r_d.ram_borrow = 1'b0;
      r_d.ram_return = 1'b0;
      r_d.rec_start = 1'b0;
      r_d.rec_next = 1'b0;
      r_d.rx_we = 1'b0;
      r_d.spi.valid = 1'b0;
      if (r_q.rx_we) begin
         r_d.rx_cnt = r_q.rx_cnt + 9'd1;
      end
      // Queries answer in any state; new operations only when idle
      if (cmd.valid) begin
         r_d.done = 1'b1;
         case (cmd.code)
            CMD_CHECK_STATUS: begin
               r_d.result = (r_q.st == ST_CHECK) ? RESULT_BUSY : RESULT_OK;
            end
            CMD_RAW_RESPONSE: begin
               if (!host_holds_lock) begin
                  r_d.result = RESULT_ACCESS_DENIED;
               end else if (r_q.st inside {ST_RAW_CMD, ST_RAW_TX, ST_RAW_RX, ST_RAW_END}) begin
                  r_d.result = RESULT_BUSY;
               end else begin
                  r_d.result = r_q.raw_status;
               end
            end
            CMD_RECORD_CHECK: begin
               if (r_q.st != ST_IDLE) begin
                  r_d.result = RESULT_BUSY;
               end else if (!lock_free) begin
                  r_d.result = RESULT_ACCESS_DENIED;
               end else if (!mem_present || !directory_valid || image_is_otp) begin
                  r_d.result = RESULT_NO_DEVICE;
               end else if (!ram_free) begin
                  r_d.result = RESULT_OUT_OF_MEMORY;
               end else begin
                  r_d.result = RESULT_OK;
                  r_d.lock_take = 1'b1;
                  r_d.ram_borrow = 1'b1;
                  r_d.rec_start = 1'b1;
                  r_d.meta_only = cmd.meta_only;
                  r_d.rpt = '0;
                  r_d.st = ST_CHECK;
               end
            end
            // Refusal order: device, kind, lock, busy, range
            CMD_RAW_ISSUE: begin
               if (!mem_present) begin
                  r_d.result = RESULT_NO_DEVICE;
               end else if (!mem_is_spi) begin
                  r_d.result = RESULT_BAD_DESCRIPTOR;
               end else if (!host_holds_lock) begin
                  r_d.result = RESULT_ACCESS_DENIED;
               end else if (r_q.st != ST_IDLE) begin
                  r_d.result = RESULT_BUSY;
               end else if ({1'b0, cmd.tx_len} > RAW_TX_MAX || cmd.rx_len > RAW_RX_MAX) begin
                  r_d.result = RESULT_OUT_OF_RANGE;
               end else begin
                  r_d.result = RESULT_OK;
                  r_d.raw_status = RESULT_BUSY;
                  r_d.opcode = cmd.opcode;
                  r_d.tx_left = cmd.tx_len;
                  r_d.rx_left = cmd.rx_len;
                  r_d.tx_idx = 8'h00;
                  r_d.rx_cnt = 9'h000;
                  r_d.sel = 1'b1;
                  r_d.st = ST_RAW_CMD;
               end
            end
            default: begin
               r_d.result = RESULT_UNSUPPORTED;
            end
         endcase
      end
      case (r_q.st)
         ST_IDLE: begin
         end
         ST_CHECK: begin
            if (rec.valid) begin
               if (is_checked(r_q.meta_only, rec.rtype)) begin
                  r_d.rpt.count = r_q.rpt.count + 16'h0001;
               end
               if (is_filler(rec.rtype)) begin
                  r_d.st = ST_IDLE;
               end else if (is_checked(r_q.meta_only, rec.rtype) &&
                     rec.hdr_sum != rec.calc_sum) begin
                  r_d.rpt.error = RESULT_CHECKSUM;
                  r_d.rpt.rtype = rec.rtype;
                  r_d.rpt.length = rec.length;
                  r_d.rpt.hdr_sum = rec.hdr_sum;
                  r_d.rpt.calc_sum = rec.calc_sum;
                  r_d.rpt.addr = rec.addr;
                  r_d.st = ST_IDLE;
               end else if (rec.last) begin
                  r_d.st = ST_IDLE;
               end else begin
                  r_d.rec_next = 1'b1;
               end
               if (r_d.st == ST_IDLE) begin
                  r_d.lock_release = 1'b1;
                  r_d.ram_return = 1'b1;
               end
            end
         end
         ST_RAW_CMD: begin
            r_d.spi = '{valid: 1'b1, write: 1'b1, data: r_q.opcode};
            r_d.st = ST_RAW_TX;
         end
         ST_RAW_TX: begin
            if (spi_ack) begin
               if (r_q.tx_left != 8'h00) begin
                  r_d.spi = '{valid: 1'b1, write: 1'b1, data: tx_byte};
                  r_d.tx_left = r_q.tx_left - 8'h01;
                  r_d.tx_idx = r_q.tx_idx + 8'h01;
               end else if (r_q.rx_left != 9'h000) begin
                  r_d.spi = '{valid: 1'b1, write: 1'b0, data: 8'h00};
                  r_d.st = ST_RAW_RX;
               end else begin
                  r_d.st = ST_RAW_END;
               end
            end
         end
         ST_RAW_RX: begin
            if (spi_ack) begin
               // Engine holds the byte only with ack; write it next cycle
               r_d.rx_data = spi_rx_byte;
               r_d.rx_we = 1'b1;
               r_d.rx_left = r_q.rx_left - 9'h001;
               if (r_q.rx_left != 9'h001) begin
                  r_d.spi = '{valid: 1'b1, write: 1'b0, data: 8'h00};
               end else begin
                  r_d.st = ST_RAW_END;
               end
            end
         end
         ST_RAW_END: begin
            // Select drops only after the last byte's ack
            r_d.sel = 1'b0;
            r_d.raw_status = RESULT_OK;
            r_d.st = ST_IDLE;
         end
         default: begin
            r_d.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         r_q <= '0;
         // No raw command yet, so the response query reads ok
         r_q.st <= ST_IDLE;
         r_q.raw_status <= RESULT_OK;
      end else begin
         r_q <= r_d;
      end
   end

   assign cmd_result = r_q.result;
   assign cmd_done = r_q.done;
   assign lock_take = r_q.lock_take;
   assign lock_release = r_q.lock_release;
   assign ram_borrow = r_q.ram_borrow;
   assign ram_return = r_q.ram_return;
   assign rec_start = r_q.rec_start;
   assign rec_meta_only = r_q.meta_only;
   assign rec_next = r_q.rec_next;
   assign report = r_q.rpt;
   assign tx_index = r_q.tx_idx;
   assign spi_req = r_q.spi;
   assign spi_select = r_q.sel;
   assign rx_count = r_q.rx_cnt;
endmodule
`default_nettype wire

// ==== tb/nvrc_top_sva.sv ====
// Assertion checker for nvrc_top, seeing only its ports.
// Attached to every nvrc_top by the bind after the module.
`default_nettype none
module nvrc_top_sva
   import nvrc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Command channel
   input wire nvrc_cmd_type cmd,
   input wire logic [7:0] cmd_result,
   input wire logic cmd_done,
   // Environment and side pulses
   input wire logic mem_present,
   input wire logic mem_is_spi,
   input wire logic host_holds_lock,
   input wire logic lock_take,
   input wire logic lock_release,
   input wire logic ram_borrow,
   input wire logic ram_return,
   input wire logic rec_start,
   // Byte engine
   input wire nvrc_spi_req_type spi_req,
   input wire logic spi_select,
   input wire logic spi_ack
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence s_raw_req;
      cmd.valid && cmd.code == CMD_RAW_ISSUE;
   endsequence
   sequence s_opcode_out;
      spi_req.valid && spi_req.write;
   endsequence
   a_done_follows: assert property (cmd.valid |=> cmd_done)
      else $error("done missing after command");
   a_done_only: assert property (!cmd.valid |=> !cmd_done)
      else $error("done without command");
   a_take_pair: assert property (lock_take |-> cmd_done && ram_borrow && rec_start)
      else $error("lock taken without ram and start");
   a_release_pair: assert property (lock_release |-> ram_return)
      else $error("lock released without ram return");
   a_raw_nodev: assert property (s_raw_req ##0 !mem_present
      |=> cmd_result == RESULT_NO_DEVICE)
      else $error("missing memory not refused");
   a_raw_notspi: assert property (s_raw_req ##0 mem_present && !mem_is_spi
      |=> cmd_result == RESULT_BAD_DESCRIPTOR)
      else $error("non spi memory not refused");
   a_raw_nolock: assert property (s_raw_req ##0 mem_present && mem_is_spi && !host_holds_lock
      |=> cmd_result == RESULT_ACCESS_DENIED)
      else $error("raw command without lock not refused");
   a_opcode_first: assert property ($rose(spi_select) |=> s_opcode_out)
      else $error("opcode not first after select");
   a_req_selected: assert property (spi_req.valid |-> spi_select)
      else $error("byte request while deselected");
   a_ack_moves: assert property (spi_ack && spi_select
      |-> ##[1:3] (spi_req.valid || !spi_select))
      else $error("transaction stalls after ack");
endmodule
bind nvrc_top nvrc_top_sva chk (.core_clk, .srst, .cmd, .cmd_result, .cmd_done,
   .mem_present, .mem_is_spi, .host_holds_lock, .lock_take, .lock_release, .ram_borrow,
   .ram_return, .rec_start, .spi_req, .spi_select, .spi_ack);
`default_nettype wire

// ==== tb/nvrc_spi_mem_model.sv ====
// Behavioural SPI memory behind the byte engine.
// Answers after one or four cycles; read data is a counted pattern.
`default_nettype none
module nvrc_spi_mem_model
   import nvrc_pkg::*;
(
   // Clock and pace
   input wire logic core_clk,
   input wire logic slow,
   // Byte engine
   input wire nvrc_spi_req_type spi_req,
   input wire logic spi_select,
   output logic spi_ack,
   output logic [7:0] spi_rx_byte
);
   int wait_n = 0;
   logic read_q = 1'b0;
   logic [7:0] rcnt = 8'h00;
   initial spi_ack = 1'b0;
   initial spi_rx_byte = 8'h5a;
   always @(posedge core_clk) begin
      spi_ack <= 1'b0;
      // Data only valid with ack, so it churns otherwise
      spi_rx_byte <= ~spi_rx_byte;
      if (!spi_select) rcnt <= 8'h00;
      if (spi_req.valid) begin
         wait_n <= slow ? 4 : 1;
         read_q <= !spi_req.write;
      end else if (wait_n == 1) begin
         spi_ack <= 1'b1;
         wait_n <= 0;
         if (read_q) begin
            spi_rx_byte <= 8'h3c ^ rcnt;
            rcnt <= rcnt + 8'h01;
         end
      end else if (wait_n > 1) begin
         wait_n <= wait_n - 1;
      end
   end
endmodule
`default_nettype wire

// ==== tb/test_nvrc_top.sv ====
// Self-checking bench for nvrc_top; bench plays host and record walker.
// Assumes the SPI memory model; inputs change at falling edges.
`default_nettype none
module test_nvrc_top
   import nvrc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0, srst = 1'b1, slow = 1'b0;
   nvrc_cmd_type cmd = '0;
   nvrc_record_type rec = '0;
   logic [6:0] env = 7'h77;
   logic mem_present, mem_is_spi, directory_valid, image_is_otp, host_holds_lock;
   logic lock_free, ram_free, cmd_done, lock_take, lock_release, ram_borrow, ram_return;
   logic rec_start, rec_meta_only, rec_next, spi_select, spi_ack;
   logic [7:0] cmd_result, tx_index, tx_byte, spi_rx_byte, rx_rd_data;
   logic [7:0] rx_rd_addr = 8'h00;
   logic [8:0] rx_count;
   nvrc_report_type report;
   nvrc_spi_req_type spi_req;
   int fail_count = 0, cmp_count = 0, rel_n = 0, ret_n = 0, runs = 0;
   logic [31:0] seed = 32'd92117;
   logic [8:0] q[$];
   logic [7:0] tx_mem[256] = '{default: 8'h00};
   logic [2:0] side;
   logic nxt;
   assign {mem_present, mem_is_spi, directory_valid, image_is_otp} = env[6:3];
   assign {host_holds_lock, lock_free, ram_free} = env[2:0];
   assign tx_byte = tx_mem[tx_index];
   always #50 core_clk = ~core_clk;
   nvrc_top dut (.core_clk, .srst, .cmd, .cmd_result, .cmd_done, .mem_present, .mem_is_spi,
      .directory_valid, .image_is_otp, .host_holds_lock, .lock_free, .lock_take, .lock_release,
      .ram_free, .ram_borrow, .ram_return, .rec_start, .rec_meta_only, .rec_next, .rec, .report,
      .tx_index, .tx_byte, .spi_req, .spi_select, .spi_ack, .spi_rx_byte, .rx_rd_addr,
      .rx_rd_data, .rx_count);
   nvrc_spi_mem_model far (.core_clk, .slow, .spi_req, .spi_select, .spi_ack, .spi_rx_byte);
   always @(posedge core_clk) begin
      if (spi_req.valid) q.push_back({spi_req.write, spi_req.data});
      rel_n += lock_release;
      ret_n += ram_return;
   end
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction
   function automatic logic [7:0] exp_rx(input int i);
      return 8'h3c ^ i[7:0];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_res(input logic [7:0] got, input logic [7:0] exp);
      chk({24'h0, got}, {24'h0, exp});
   endtask
   task automatic send(input logic [15:0] c, input logic [7:0] op, input logic [7:0] tx,
         input logic [8:0] rx, input logic meta, input logic [7:0] exp, input bit ck);
      cmd = '{1'b1, c, meta, op, tx, rx};
      @(negedge core_clk);
      // Done and side pulses stand for one cycle only
      cmd.valid = 1'b0;
      side = {lock_take, ram_borrow, rec_start};
      chk(cmd_done, 1'b1);
      if (ck) chk_res(cmd_result, exp);
      @(negedge core_clk);
   endtask
   task automatic refuse(input logic [15:0] c, input logic [6:0] e, input logic [7:0] tx,
         input logic [8:0] rx, input logic [7:0] exp);
      env = e;
      send(c, rnd(), tx, rx, 1'b0, exp, 1'b1);
   endtask
   task automatic raw_run(input logic [7:0] tx, input logic [8:0] rx);
      logic [7:0] op;
      int n;
      op = rnd();
      for (int i = 0; i < 256; i++) tx_mem[i] = rnd();
      q.delete();
      send(CMD_RAW_ISSUE, op, tx, rx, 1'b0, RESULT_OK, 1'b1);
      if (slow && tx + rx > 2) begin
         send(CMD_RAW_ISSUE, op, tx, rx, 1'b0, RESULT_BUSY, 1'b1);
         send(CMD_RECORD_CHECK, 8'h00, 8'h00, 9'h0, 1'b0, RESULT_BUSY, 1'b1);
      end
      n = 0;
      do begin
         send(CMD_RAW_RESPONSE, 8'h00, 8'h00, 9'h0, 1'b0, 8'h00, 1'b0);
         n++;
      end while (cmd_result === RESULT_BUSY && n < 3000);
      chk_res(cmd_result, RESULT_OK);
      chk(spi_select, 1'b0);
      chk(q.size(), 1 + tx + rx);
      chk(q[0], {1'b1, op});
      for (int i = 0; i < tx; i++) chk(q[1 + i], {1'b1, tx_mem[i]});
      for (int i = 0; i < rx; i++) chk(q[1 + tx + i][8], 1'b0);
      chk(rx_count, rx);
      for (int i = 0; i < rx; i++) begin
         rx_rd_addr = i[7:0];
         @(negedge core_clk);
         chk(rx_rd_data, exp_rx(i));
      end
      $display("test raw tx %0d rx %0d done", tx, rx);
   endtask
   task automatic feed(input logic [7:0] t, input logic [15:0] sum, input logic last);
      rec = '{1'b1, last, t, 16'h0010, 16'h1234, sum, {24'h000001, t}};
      @(negedge core_clk);
      rec.valid = 1'b0;
      nxt = rec_next;
      repeat (2) @(negedge core_clk);
   endtask
   task automatic check_run(input logic meta, input logic [7:0] t0, input logic [15:0] s0,
         input logic [7:0] t1, input logic [15:0] s1, input logic [31:0] cnt,
         input logic [7:0] err);
      send(CMD_RECORD_CHECK, 8'h00, 8'h00, 9'h0, meta, RESULT_OK, 1'b1);
      runs++;
      chk(side, 3'b111);
      chk(rec_meta_only, meta);
      feed(t0, s0, 1'b0);
      chk(nxt, 1'b1);
      send(CMD_CHECK_STATUS, 8'h00, 8'h00, 9'h0, 1'b0, RESULT_BUSY, 1'b1);
      feed(t1, s1, t1 != REC_NULL_EXT);
      chk(nxt, 1'b0);
      repeat (3) @(negedge core_clk);
      send(CMD_CHECK_STATUS, 8'h00, 8'h00, 9'h0, 1'b0, RESULT_OK, 1'b1);
      chk(report.error, err);
      if (err != RESULT_OK) chk({report.length, report.hdr_sum}, 32'h00101234);
      if (cnt != 32'hffffffff) chk(report.count, cnt);
      if (err == RESULT_CHECKSUM) chk({report.rtype, report.calc_sum}, {t1, s1});
      if (err == RESULT_CHECKSUM) chk(report.addr, {24'h000001, t1});
      chk(rel_n, runs);
      chk(ret_n, runs);
      $display("test check meta %0d done", meta);
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #6000000;
      fail_count++;
      end_of_test();
   end
   initial begin
      repeat (20) @(negedge core_clk);
      srst = 1'b0;
      refuse(CMD_RAW_ISSUE, 7'h37, 8'd0, 9'd0, RESULT_NO_DEVICE);
      refuse(CMD_RAW_ISSUE, 7'h57, 8'd0, 9'd0, RESULT_BAD_DESCRIPTOR);
      refuse(CMD_RAW_ISSUE, 7'h73, 8'd0, 9'd0, RESULT_ACCESS_DENIED);
      refuse(CMD_RAW_ISSUE, 7'h77, 8'd254, 9'd0, RESULT_OUT_OF_RANGE);
      refuse(CMD_RAW_ISSUE, 7'h77, 8'd0, 9'd257, RESULT_OUT_OF_RANGE);
      refuse(CMD_RECORD_CHECK, 7'h75, 8'd0, 9'd0, RESULT_ACCESS_DENIED);
      refuse(CMD_RECORD_CHECK, 7'h37, 8'd0, 9'd0, RESULT_NO_DEVICE);
      refuse(CMD_RECORD_CHECK, 7'h67, 8'd0, 9'd0, RESULT_NO_DEVICE);
      refuse(CMD_RECORD_CHECK, 7'h7f, 8'd0, 9'd0, RESULT_NO_DEVICE);
      refuse(CMD_RECORD_CHECK, 7'h76, 8'd0, 9'd0, RESULT_OUT_OF_MEMORY);
      refuse(16'h8511, 7'h77, 8'd0, 9'd0, RESULT_UNSUPPORTED);
      chk(rel_n, 0);
      env = 7'h77;
      $display("test refusals done");
      check_run(1'b0, REC_DIRECTORY, 16'h1234, 8'h20, 16'h9999, 32'd2,
         RESULT_CHECKSUM);
      check_run(1'b1, 8'h20, 16'h0bad, REC_CMD_SEQ, 16'h1234, 32'd1,
         RESULT_OK);
      check_run(1'b0, REC_PATCH_DIR, 16'h1234, REC_NULL_EXT, 16'h1234, 32'hffffffff,
         RESULT_OK);
      for (int k = 0; k < 4; k++) begin
         slow = rnd() > 8'h80;
         raw_run(rnd() & 8'h0f, {1'b0, rnd() & 8'h0f});
      end
      slow = 1'b0;
      raw_run(8'd0, 9'd0);
      slow = 1'b1;
      raw_run(8'd253, 9'd256);
      end_of_test();
   end
endmodule
`default_nettype wire
